// ==== hdl/acs_regs.vh ====
// register offsets, field positions, reset values and encodings of the input select block
`ifndef ACS_REGS_VH
`define ACS_REGS_VH

// ****************************************************************************
// register map (byte addresses)
// ****************************************************************************
`define ACS_INPUT_SELECT_ADDR 12'h000
`define ACS_DIVISOR_ADDR 12'h004
`define ACS_STATUS_ADDR 12'h008
`define ACS_ADDR_W 12

// ****************************************************************************
// field layout of the input select word
// ****************************************************************************
`define ACS_MUX_B_NEG_BIT 15
`define ACS_MUX_B_POS_HI 11
`define ACS_MUX_B_POS_LO 8
`define ACS_MUX_A_NEG_BIT 7
`define ACS_MUX_A_POS_HI 3
`define ACS_MUX_A_POS_LO 0
`define ACS_SELECT_MASK 16'h8f8f
`define ACS_SELECT_LANE_MASK 8'h8f
`define ACS_SELECT_RESET 16'h0000

// ****************************************************************************
// encodings and divisor
// ****************************************************************************
`define ACS_POS_BANDGAP 4'hf
`define ACS_POS_LAST_INPUT 4'hc
`define ACS_DIV_W 8
`define ACS_DIV_RESET 8'h00

`endif

// ==== hdl/acs_input_decode.v ====
// decoder of one multiplexer setting into one-hot input selects
`timescale 1ns/100ps
`include "acs_regs.vh"
module acs_input_decode #(
    parameter NUM_INPUTS = 13
) (
    input wire [3:0] pos_code,
    input wire neg_code,
    output wire [NUM_INPUTS-1:0] pos_input_sel,
    output wire pos_bandgap_sel,
    output wire pos_invalid,
    output wire neg_input1_sel,
    output wire neg_reference_sel
);

    // ************************************************************************
    // positive side: one line per analog input
    // ************************************************************************
    genvar i;
    generate
        for (i = 0; i < NUM_INPUTS; i = i + 1) begin : g_pos
            localparam [3:0] CODE = i;
            assign pos_input_sel[i] = (pos_code == CODE);
        end
    endgenerate

    // bandgap on the all-ones code; others above the last input select nothing
    assign pos_bandgap_sel = (pos_code == `ACS_POS_BANDGAP);
    assign pos_invalid = (pos_code > `ACS_POS_LAST_INPUT) && !pos_bandgap_sel;

    // negative side: input 1 or negative reference
    assign neg_input1_sel = neg_code;
    assign neg_reference_sel = !neg_code;

endmodule

// ==== hdl/acs_clock_divider.v ====
// conversion clock enable generator, one pulse every divisor+1 cycles
`timescale 1ns/100ps
module acs_clock_divider #(
    parameter DIV_W = 8
) (
    input wire pclk,
    input wire presetn,
    input wire [DIV_W-1:0] divisor,
    output reg conv_tick
);

    reg [DIV_W-1:0] count;

    // ************************************************************************
    // period counter; a new divisor applies at once, compared with the count every cycle
    // ************************************************************************
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count <= {DIV_W{1'b0}};
            conv_tick <= 1'b0;
        end else if (count >= divisor) begin
            count <= {DIV_W{1'b0}};
            conv_tick <= 1'b1; // divisor zero keeps tick high every cycle
        end else begin
            count <= count + 1'b1;
            conv_tick <= 1'b0;
        end
    end

endmodule

// ==== hdl/acs_input_select.v ====
// converter input select register, conversion clock divider and APB slave
// ****************************************************************************
// How it works
// - bits 11..8 pick setting B positive input: inputs 0-12, 1111 bandgap.
// - bits 3..0 pick setting A positive input, same encoding as B.
// - bit 15 set routes input 1 to B negative, else negative reference.
// - bit 7 set routes input 1 to A negative, else negative reference.
// ****************************************************************************
`timescale 1ns/100ps
`include "acs_regs.vh"
module acs_input_select #(
    parameter NUM_INPUTS = 13,
    parameter DIV_W = `ACS_DIV_W
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [`ACS_ADDR_W-1:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    output reg [NUM_INPUTS-1:0] mux_a_positive_select,
    output reg mux_a_bandgap_select,
    output reg mux_a_negative_select,
    output reg [NUM_INPUTS-1:0] mux_b_positive_select,
    output reg mux_b_bandgap_select,
    output reg mux_b_negative_select,
    output reg conversion_clock
);

    // ************************************************************************
    // declarations
    // ************************************************************************
    reg [15:0] adc_input_select;
    reg [DIV_W-1:0] conversion_clock_divisor;
    wire [NUM_INPUTS-1:0] a_pos;
    wire [NUM_INPUTS-1:0] b_pos;
    wire a_bg;
    wire b_bg;
    wire a_inv;
    wire b_inv;
    wire a_n1;
    wire b_n1;
    wire conv_tick;
    wire setup;
    wire access;
    reg [31:0] next_prdata;
    reg next_slverr;

    // address decode used for the error flag
    function addr_known;
        input [`ACS_ADDR_W-1:0] a;
        begin
            addr_known = (a == `ACS_INPUT_SELECT_ADDR) || (a == `ACS_DIVISOR_ADDR) ||
                (a == `ACS_STATUS_ADDR);
        end
    endfunction

    assign setup = psel && !penable;
    assign access = psel && penable && pready;

    // ************************************************************************
    // apb slave: no wait state, ready rises in the first access cycle
    // ************************************************************************
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else if (setup) begin
            pready <= 1'b1;
            pslverr <= next_slverr;
            prdata <= next_prdata;
        end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end
    end

    // read data and error for the request in setup
    always @* begin
        next_slverr = !addr_known(paddr);
        next_prdata = 32'h0000_0000;
        if (!pwrite) begin
            case (paddr)
                `ACS_INPUT_SELECT_ADDR: begin
                    next_prdata = {16'h0000, adc_input_select & `ACS_SELECT_MASK};
                end
                `ACS_DIVISOR_ADDR: begin
                    next_prdata[DIV_W-1:0] = conversion_clock_divisor;
                end
                `ACS_STATUS_ADDR: begin
                    next_prdata[1:0] = {b_inv, a_inv};
                    next_prdata[2] = conv_tick;
                end
                default: begin
                    next_prdata = 32'h0000_0000;
                end
            endcase
        end
    end

    // ************************************************************************
    // registers: written at the completing access edge, per byte lane
    // ************************************************************************
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            adc_input_select <= `ACS_SELECT_RESET;
            conversion_clock_divisor <= {DIV_W{1'b0}};
        end else if (access && pwrite) begin
            if (paddr == `ACS_INPUT_SELECT_ADDR) begin
                if (pstrb[0]) begin
                    adc_input_select[7:0] <= pwdata[7:0] & `ACS_SELECT_LANE_MASK;
                end
                if (pstrb[1]) begin
                    adc_input_select[15:8] <= pwdata[15:8] & `ACS_SELECT_LANE_MASK;
                end
            end
            if (paddr == `ACS_DIVISOR_ADDR && pstrb[0]) begin
                conversion_clock_divisor <= pwdata[DIV_W-1:0];
            end
        end
    end

    // ************************************************************************
    // decode of both multiplexer settings
    // ************************************************************************
    acs_input_decode #(
        .NUM_INPUTS(NUM_INPUTS)
    ) u_dec_a (
        .pos_code(adc_input_select[`ACS_MUX_A_POS_HI:`ACS_MUX_A_POS_LO]),
        .neg_code(adc_input_select[`ACS_MUX_A_NEG_BIT]),
        .pos_input_sel(a_pos),
        .pos_bandgap_sel(a_bg),
        .pos_invalid(a_inv),
        .neg_input1_sel(a_n1),
        .neg_reference_sel()
    );

    acs_input_decode #(
        .NUM_INPUTS(NUM_INPUTS)
    ) u_dec_b (
        .pos_code(adc_input_select[`ACS_MUX_B_POS_HI:`ACS_MUX_B_POS_LO]),
        .neg_code(adc_input_select[`ACS_MUX_B_NEG_BIT]),
        .pos_input_sel(b_pos),
        .pos_bandgap_sel(b_bg),
        .pos_invalid(b_inv),
        .neg_input1_sel(b_n1),
        .neg_reference_sel()
    );

    acs_clock_divider #(
        .DIV_W(DIV_W)
    ) u_div (
        .pclk(pclk),
        .presetn(presetn),
        .divisor(conversion_clock_divisor),
        .conv_tick(conv_tick)
    );

    // ************************************************************************
    // registered outputs, one cycle behind the register
    // ************************************************************************
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mux_a_positive_select <= {NUM_INPUTS{1'b0}};
            mux_a_bandgap_select <= 1'b0;
            mux_a_negative_select <= 1'b0;
            mux_b_positive_select <= {NUM_INPUTS{1'b0}};
            mux_b_bandgap_select <= 1'b0;
            mux_b_negative_select <= 1'b0;
            conversion_clock <= 1'b0;
        end else begin
            mux_a_positive_select <= a_pos;
            mux_a_bandgap_select <= a_bg;
            mux_a_negative_select <= a_n1;
            mux_b_positive_select <= b_pos;
            mux_b_bandgap_select <= b_bg;
            mux_b_negative_select <= b_n1;
            conversion_clock <= conv_tick;
        end
    end

endmodule

// ==== sim/acs_select_monitor.sv ====
// port checker of the converter input select block
`timescale 1ns/100ps
module acs_select_monitor #(
    parameter NUM_INPUTS = 13,
    parameter DIV_W = 8
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire [NUM_INPUTS-1:0] mux_a_positive_select,
    input wire mux_a_bandgap_select,
    input wire mux_a_negative_select,
    input wire [NUM_INPUTS-1:0] mux_b_positive_select,
    input wire mux_b_bandgap_select,
    input wire mux_b_negative_select,
    input wire conversion_clock
);
    // completed access, and lane writes to the select word
    wire acc = psel && penable && pready;
    wire wr0 = acc && pwrite && paddr == 12'h000 && pstrb[0];
    wire wr1 = acc && pwrite && paddr == 12'h000 && pstrb[1];
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // codes 1101 and 1110 drive no input line
    function [NUM_INPUTS-1:0] hot(input [3:0] c);
        hot = (c < 4'hd) ? ({{(NUM_INPUTS-1){1'b0}}, 1'b1} << c) : {NUM_INPUTS{1'b0}};
    endfunction
    // mux outputs trail the register by one cycle, so two edges after the write
    property p_apos; wr0 |=> ##1 mux_a_positive_select == hot($past(pwdata[3:0], 2)); endproperty
    a_apos: assert property (p_apos) else $error("bad A positive");
    property p_bpos; wr1 |=> ##1 mux_b_positive_select == hot($past(pwdata[11:8], 2)); endproperty
    a_bpos: assert property (p_bpos) else $error("bad B positive");
    property p_abg; wr0 |=> ##1 mux_a_bandgap_select == ($past(pwdata[3:0], 2) == 4'hf); endproperty
    a_abg: assert property (p_abg) else $error("bad A bandgap");
    property p_bbg; wr1 |=> ##1 mux_b_bandgap_select == ($past(pwdata[11:8], 2) == 4'hf); endproperty
    a_bbg: assert property (p_bbg) else $error("bad B bandgap");
    property p_aneg; wr0 |=> ##1 mux_a_negative_select == $past(pwdata[7], 2); endproperty
    a_aneg: assert property (p_aneg) else $error("bad A negative");
    property p_bneg; wr1 |=> ##1 mux_b_negative_select == $past(pwdata[15], 2); endproperty
    a_bneg: assert property (p_bneg) else $error("bad B negative");
    property p_rzero; acc && !pwrite && paddr == 12'h000 |-> (prdata & 32'hffff_7070) == 0; endproperty
    a_rzero: assert property (p_rzero) else $error("bad unused bits");
    property p_err; acc |-> pslverr ==
        (paddr != 12'h000 && paddr != 12'h004 && paddr != 12'h008); endproperty
    a_err: assert property (p_err) else $error("bad error flag");
endmodule
bind acs_input_select acs_select_monitor #(.NUM_INPUTS(NUM_INPUTS), .DIV_W(DIV_W)) u_mon (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .mux_a_positive_select(mux_a_positive_select),
    .mux_a_bandgap_select(mux_a_bandgap_select), .mux_a_negative_select(mux_a_negative_select),
    .mux_b_positive_select(mux_b_positive_select), .mux_b_bandgap_select(mux_b_bandgap_select),
    .mux_b_negative_select(mux_b_negative_select), .conversion_clock(conversion_clock));

// ==== sim/test_adc_channel_select_and_clock.sv ====
// self-checking bench of the converter input select block
`timescale 1ns/100ps
`include "acs_regs.vh"
`define CHK(a, b) begin \
    checks_done = checks_done + 1; \
    if ((a) !== (b)) begin \
        fails = fails + 1; \
        $display("BAD %0t mismatch", $time); \
    end end
module test_adc_channel_select_and_clock;
    reg pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err;
    reg [11:0] paddr = 0;
    reg [31:0] pwdata = 0, rd, w, rnd = 32'h0000_8eb0;
    reg [3:0] pstrb = 0, s, d;
    reg [15:0] sh = 0;
    wire [31:0] prdata;
    wire pready, pslverr, abg, aneg, bbg, bneg, conv;
    wire [12:0] apos, bpos;
    integer fails = 0, checks_done = 0, i, n;
    acs_input_select dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .mux_a_positive_select(apos),
        .mux_a_bandgap_select(abg), .mux_a_negative_select(aneg), .mux_b_positive_select(bpos),
        .mux_b_bandgap_select(bbg), .mux_b_negative_select(bneg), .conversion_clock(conv));
    // 50 MHz clock
    initial begin
        forever #10 pclk = ~pclk;
    end
    // next pseudo-random word
    function [31:0] lfsr(input [31:0] v);
        lfsr = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    // expected one-hot line, none for the two unused codes
    function [12:0] hot(input [3:0] c);
        hot = (c < `ACS_POS_LAST_INPUT + 4'h1) ? (13'h0001 << c) : 13'h0000;
    endfunction
    // expected status flag: codes 1101 and 1110 select nothing
    function unused_code(input [3:0] c);
        unused_code = (c == 4'hd) || (c == 4'he);
    endfunction
    // one apb transfer; waits for pready, takes the answer at that edge
    task apb(input wr, input [11:0] a, input [31:0] dat, input [3:0] st);
        begin
            @(posedge pclk);
            psel <= 1;
            pwrite <= wr;
            paddr <= a;
            pwdata <= dat;
            pstrb <= st;
            @(posedge pclk);
            penable <= 1;
            @(posedge pclk);
            while (pready !== 1'b1) @(posedge pclk);
            rd = prdata;
            err = pslverr;
            psel <= 0;
            penable <= 0;
        end
    endtask
    // verdict and end of run
    task complete_run;
        begin
            if (fails == 0 && checks_done > 0)
                $display("Run complete: PASS");
            else
                $display("Run complete: FAIL");
            $finish;
        end
    endtask
    // hang guard at 10000 cycles, far beyond the fewer than one thousand cycles needed
    initial begin
        #200000;
        fails = fails + 1;
        complete_run;
    end
    // main sequence
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1;
        apb(0, `ACS_INPUT_SELECT_ADDR, 0, 0);
        `CHK(rd, 32'h0000_0000)
        `CHK({apos, aneg, bpos, bneg}, {13'h0001, 1'b0, 13'h0001, 1'b0})
        for (i = 0; i < 32; i = i + 1) begin
            rnd = lfsr(rnd);
            w = {rnd[31:12], i[3:0] ^ 4'ha, rnd[7:4], i[3:0]};
            s = (i < 6) ? rnd[3:0] : 4'hf;
            if (s[0])
                sh[7:0] = w[7:0] & 8'h8f;
            if (s[1])
                sh[15:8] = w[15:8] & 8'h8f;
            apb(1, `ACS_INPUT_SELECT_ADDR, w, s);
            @(posedge pclk);
            #1;
            `CHK({apos, abg}, {hot(sh[3:0]), sh[3:0] == 4'hf})
            `CHK({bpos, bbg}, {hot(sh[11:8]), sh[11:8] == 4'hf})
            `CHK(aneg, sh[7])
            `CHK(bneg, sh[15])
            apb(0, `ACS_INPUT_SELECT_ADDR, 0, 0);
            `CHK(rd, {16'h0000, sh})
            // divisor still zero here, so the live tick bit reads one
            apb(0, `ACS_STATUS_ADDR, 0, 0);
            `CHK(rd[1:0], {unused_code(sh[11:8]), unused_code(sh[3:0])})
            `CHK(rd[31:2], {29'h000_0000, 1'b1})
        end
        // unmapped place: refused, nothing written
        apb(1, 12'h010, 32'hffff_ffff, 4'hf);
        `CHK(err, 1'b1)
        apb(0, 12'h010, 0, 0);
        `CHK({err, rd}, {1'b1, 32'h0000_0000})
        apb(0, `ACS_INPUT_SELECT_ADDR, 0, 0);
        `CHK(rd, {16'h0000, sh})
        // divisor sweep: tick spacing is divisor plus one cycles
        for (i = 0; i < 4; i = i + 1) begin
            rnd = lfsr(rnd);
            d = (i == 3) ? rnd[3:0] : i[3:0] * 4'h3;
            apb(1, `ACS_DIVISOR_ADDR, {28'h000_0000, d}, 4'h1);
            apb(0, `ACS_DIVISOR_ADDR, 0, 0);
            `CHK(rd, {28'h000_0000, d})
            repeat (40) @(posedge pclk);
            while (conv !== 1'b1) @(posedge pclk);
            n = 0;
            do begin
                @(posedge pclk);
                n = n + 1;
            end while (conv !== 1'b1 && n < 40);
            `CHK(n, d + 1)
        end
        // second reset in mid-run: every implemented bit back to zero
        presetn <= 0;
        repeat (4) @(posedge pclk);
        presetn <= 1;
        apb(0, `ACS_INPUT_SELECT_ADDR, 0, 0);
        `CHK(rd, 32'h0000_0000)
        apb(0, `ACS_DIVISOR_ADDR, 0, 0);
        `CHK(rd, 32'h0000_0000)
        `CHK({apos, abg, aneg, bpos, bbg, bneg}, {13'h0001, 2'b00, 13'h0001, 2'b00})
        complete_run;
    end
endmodule
